// ---- hw/tpr_cfg.svh ----
// constants for the dual 8-bit timer pair
`ifndef TPR_CFG_SVH
`define TPR_CFG_SVH
`define TPR_MODE_8BIT 2'h0
`define TPR_MODE_16BIT 2'h1
`define TPR_MODE_PULSE 2'h2
`define TPR_MODE_PWM 2'h3
`define TPR_PWM_OFF 2'h0
`define TPR_PWM_2P6 2'h1
`define TPR_PWM_2P7 2'h2
`define TPR_PWM_2P8 2'h3
`define TPR_FLOP_CMD_NONE 2'h0
`define TPR_FLOP_CMD_SET 2'h1
`define TPR_FLOP_CMD_CLR 2'h2
`define TPR_UCLK_LOWER_MATCH 2'h0
`define TPR_CNT_RESET 8'h00
`define TPR_CMP_RESET 8'h00
`endif

// ---- hw/tpr_pkg.sv ----
// types for the dual 8-bit timer pair
package tpr_pkg;
  typedef enum logic [1:0] {TPR_M8, TPR_M16, TPR_MPULSE, TPR_MPWM} tpr_mode_t;
endpackage : tpr_pkg

// ---- hw/tpr_cmp8.sv ----
// 8-bit comparator where a zero compare value means 100h
`timescale 1ns/10ps
module tpr_cmp8 #(
  parameter int W = 8
) (
  input wire logic [W-1:0] count,
  input wire logic [W-1:0] compare,
  input wire logic tick,
  output logic hit
);
  // a tick with counter at all ones wraps, which is the 100h match
  assign hit = tick && ((compare == '0) ? (count == '1) : (count + 1'b1 == compare));
endmodule : tpr_cmp8

// ---- hw/tpr_cbuf.sv ----
// double buffer for the lower compare register
`timescale 1ns/10ps
`include "tpr_cfg.svh"
module tpr_cbuf #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  input wire logic dbuf_en,
  input wire logic shift,
  output logic [W-1:0] value
);
  typedef struct packed {
    logic [W-1:0] buf_v;
    logic [W-1:0] reg_v;
  } tpr_cbuf_st_t;
  tpr_cbuf_st_t st_q, st_d;
  always_comb begin
    st_d = st_q;
    if (wr) begin
      st_d.buf_v = wdata;
      if (!dbuf_en) begin
        st_d.reg_v = wdata;
      end
    end
    // buffered value moves over on the shift event
    if (dbuf_en && shift) begin
      st_d.reg_v = wr ? wdata : st_q.buf_v;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign value = st_q.reg_v;
endmodule : tpr_cbuf

// ---- hw/tpr_timer_pair.sv ----
// dual 8-bit timer pair with 16-bit, pulse and pwm modes
`timescale 1ns/10ps
`include "tpr_cfg.svh"
module tpr_timer_pair
  import tpr_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] pair_mode_field,
  input wire logic [1:0] pwm_cycle_select,
  input wire logic [1:0] upper_clock_select,
  input wire logic lower_tick,
  input wire logic [2:0] upper_tick,
  input wire logic lower_run_bit,
  input wire logic upper_run_bit,
  input wire logic dbuf_enable,
  input wire logic lower_cmp_wr,
  input wire logic upper_cmp_wr,
  input wire logic [W-1:0] cmp_wdata,
  input wire logic [1:0] flop_cmd,
  input wire logic toggle_enable,
  input wire logic toggle_source_upper,
  output logic [W-1:0] lower_counter,
  output logic [W-1:0] upper_counter,
  output logic [W-1:0] lower_compare_reg,
  output logic [W-1:0] upper_compare_reg,
  output logic lower_match,
  output logic upper_match,
  output logic lower_match_irq,
  output logic upper_match_irq,
  output logic pulse_out_pin
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] lc;
    logic [W-1:0] uc;
    logic [W-1:0] ucmp;
    logic cmp_block;
    logic flop;
    logic lm;
    logic um;
    logic lirq;
    logic uirq;
  } tpr_st_t;
  tpr_st_t st_q, st_d;
  tpr_mode_t mode;
  logic is_pwm;
  logic l_hit;
  logic u_hit;
  logic l_tick_run;
  logic u_tick_run;
  logic u_src;
  logic pwm_wrap;
  logic buf_shift;
  logic [W-1:0] lcmp;
  logic [W-1:0] l_next;

  function automatic logic pwm_wrap_at(input logic [7:0] cnt, input logic [1:0] sel);
    case (sel)
      `TPR_PWM_2P6: pwm_wrap_at = (cnt[5:0] == 6'h3F);
      `TPR_PWM_2P7: pwm_wrap_at = (cnt[6:0] == 7'h7F);
      `TPR_PWM_2P8: pwm_wrap_at = (cnt == 8'hFF);
      default: pwm_wrap_at = 1'b0;
    endcase
  endfunction : pwm_wrap_at

  // ---------------------------------------------------------------
  // mode decode and comparators
  // ---------------------------------------------------------------
  assign mode = tpr_mode_t'(pair_mode_field);
  assign is_pwm = (mode == TPR_MPWM) && (pwm_cycle_select != `TPR_PWM_OFF);
  assign l_tick_run = lower_tick && lower_run_bit;
  assign pwm_wrap = is_pwm && l_tick_run && pwm_wrap_at(st_q.lc, pwm_cycle_select);

  tpr_cmp8 #(.W(W)) u_lcmp (
    .count(st_q.lc),
    .compare(lcmp),
    .tick(l_tick_run),
    .hit(l_hit)
  );

  // upper clock source: 16-bit uses lower overflow, else select field
  always_comb begin
    u_src = 1'b0;
    if (mode == TPR_M16) begin
      u_src = l_tick_run && (st_q.lc == '1);
    end else if (upper_clock_select == `TPR_UCLK_LOWER_MATCH) begin
      u_src = (mode == TPR_M8) ? l_hit : 1'b0;
    end else begin
      u_src = upper_tick[upper_clock_select - 2'h1];
    end
  end
  // pulse mode: upper comparator runs against the lower counter
  assign u_tick_run = (mode == TPR_MPULSE) ? 1'b0 : (u_src && upper_run_bit);

  tpr_cmp8 #(.W(W)) u_ucmp (
    .count((mode == TPR_MPULSE) ? st_q.lc : st_q.uc),
    .compare(st_q.ucmp),
    .tick((mode == TPR_MPULSE) ? l_tick_run : u_tick_run),
    .hit(u_hit)
  );

  assign buf_shift = (mode == TPR_MPULSE) ? u_hit : pwm_wrap;

  tpr_cbuf #(.W(W)) u_cbuf (
    .clk(clk),
    .rst(rst),
    .wr(lower_cmp_wr),
    .wdata(cmp_wdata),
    .dbuf_en(dbuf_enable),
    .shift(buf_shift),
    .value(lcmp)
  );

  assign l_next = W'(st_q.lc + 1'b1);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.lm = 1'b0;
    st_d.um = 1'b0;
    st_d.lirq = 1'b0;
    st_d.uirq = 1'b0;
    if (upper_cmp_wr) begin
      st_d.ucmp = cmp_wdata;
    end
    // low byte write holds off the 16-bit compare until high byte
    if (upper_cmp_wr) begin
      st_d.cmp_block = 1'b0;
    end else if (lower_cmp_wr) begin
      st_d.cmp_block = 1'b1;
    end
    case (mode)
      TPR_M8: begin
        if (l_tick_run) begin
          st_d.lc = l_hit ? '0 : l_next;
        end
        if (u_tick_run) begin
          st_d.uc = u_hit ? '0 : W'(st_q.uc + 1'b1);
        end
        st_d.lm = l_hit;
        st_d.um = u_hit;
        st_d.lirq = l_hit;
        st_d.uirq = u_hit;
        if (toggle_enable && (toggle_source_upper ? u_hit : l_hit)) begin
          st_d.flop = ~st_q.flop;
        end
      end
      TPR_M16: begin
        if (l_tick_run) begin
          st_d.lc = l_next;
        end
        if (u_tick_run) begin
          st_d.uc = W'(st_q.uc + 1'b1);
        end
        st_d.lm = l_hit;
        // joint match: counter pair equals full 16-bit compare value
        if (!st_q.cmp_block && l_tick_run && (st_q.uc == st_q.ucmp)
            && (lcmp != '0 ? (l_next == lcmp) : (st_q.lc == '1))) begin
          st_d.lc = '0;
          st_d.uc = '0;
          st_d.um = 1'b1;
          st_d.uirq = 1'b1;
          if (toggle_enable) begin
            st_d.flop = ~st_q.flop;
          end
        end
      end
      TPR_MPULSE: begin
        if (l_tick_run) begin
          st_d.lc = u_hit ? '0 : l_next;
        end
        st_d.lm = l_hit;
        st_d.um = u_hit;
        if (toggle_enable && (l_hit || u_hit)) begin
          st_d.flop = ~st_q.flop;
        end
      end
      default: begin
        if (is_pwm && l_tick_run) begin
          st_d.lc = pwm_wrap ? '0 : l_next;
        end
        if (u_tick_run) begin
          st_d.uc = u_hit ? '0 : W'(st_q.uc + 1'b1);
        end
        st_d.lm = is_pwm && l_hit;
        st_d.um = u_hit;
        st_d.uirq = u_hit;
        st_d.lirq = pwm_wrap;
        if (toggle_enable && is_pwm && (l_hit || pwm_wrap)) begin
          st_d.flop = ~st_q.flop;
        end
      end
    endcase
    if (!lower_run_bit) begin
      st_d.lc = '0;
    end
    if (!upper_run_bit) begin
      st_d.uc = '0;
    end
    // direct flop commands override toggling
    if (flop_cmd == `TPR_FLOP_CMD_SET) begin
      st_d.flop = 1'b1;
    end else if (flop_cmd == `TPR_FLOP_CMD_CLR) begin
      st_d.flop = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign lower_counter = st_q.lc;
  assign upper_counter = st_q.uc;
  assign lower_compare_reg = lcmp;
  assign upper_compare_reg = st_q.ucmp;
  assign lower_match = st_q.lm;
  assign upper_match = st_q.um;
  assign lower_match_irq = st_q.lirq;
  assign upper_match_irq = st_q.uirq;
  assign pulse_out_pin = st_q.flop;
endmodule : tpr_timer_pair

// ---- testbench/tpr_timer_pair_asserts.sv ----
// checker for the timer pair ports
`timescale 1ns/10ps
module tpr_timer_pair_chk #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] pair_mode_field,
  input wire logic [1:0] pwm_cycle_select,
  input wire logic lower_run_bit,
  input wire logic upper_run_bit,
  input wire logic [1:0] flop_cmd,
  input wire logic [W-1:0] lower_counter,
  input wire logic [W-1:0] upper_counter,
  input wire logic lower_match_irq,
  input wire logic upper_match_irq,
  input wire logic pulse_out_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_lrun_clear: assert property (!lower_run_bit |=> lower_counter == 8'h00)
    else $error("lower counter kept");
  a_urun_clear: assert property (!upper_run_bit |=> upper_counter == 8'h00)
    else $error("upper counter kept");
  a_flop_set: assert property (flop_cmd == 2'h1 |=> pulse_out_pin)
    else $error("flop not set");
  a_flop_clr: assert property (flop_cmd == 2'h2 |=> !pulse_out_pin)
    else $error("flop not cleared");
  a_wide_no_irq: assert property ((pair_mode_field == 2'h1)[*2] |-> !lower_match_irq)
    else $error("lower irq in 16-bit mode");
  a_wide_clear: assert property ((pair_mode_field == 2'h1)[*2] ##0 upper_match_irq
    |-> lower_counter == 8'h00 && upper_counter == 8'h00)
    else $error("joint match left counters");
  a_pulse_frozen: assert property ((pair_mode_field == 2'h2 && upper_run_bit)[*2]
    |-> $stable(upper_counter))
    else $error("upper counter moved in pulse mode");
  a_pwm_range: assert property (pair_mode_field == 2'h3 && pwm_cycle_select == 2'h1
    && lower_counter < 8'h40 ##1 pair_mode_field == 2'h3 && pwm_cycle_select == 2'h1
    |-> lower_counter < 8'h40)
    else $error("pwm counter past 2^6");
endmodule : tpr_timer_pair_chk
bind tpr_timer_pair tpr_timer_pair_chk #(.W(W)) u_chk (.clk(clk), .rst(rst),
  .pair_mode_field(pair_mode_field), .pwm_cycle_select(pwm_cycle_select),
  .lower_run_bit(lower_run_bit), .upper_run_bit(upper_run_bit), .flop_cmd(flop_cmd),
  .lower_counter(lower_counter), .upper_counter(upper_counter),
  .lower_match_irq(lower_match_irq), .upper_match_irq(upper_match_irq),
  .pulse_out_pin(pulse_out_pin));

// ---- testbench/tpr_timer_pair_tb_top.sv ----
// self-checking bench for the timer pair
`timescale 1ns/10ps
module tpr_timer_pair_tb_top;
  logic clk = 0, rst = 1, lt = 0, lr = 0, ur = 0, db = 0, lw = 0, uw = 0, te = 0;
  logic [1:0] mode = 0, pwm = 0, ucs = 0, fcmd = 0;
  logic [7:0] wd = 0, lc, uc, lcr, ucr;
  logic lm, um, li, ui, pin, pin_q;
  int mismatches = 0, comparisons = 0, n_lm, n_li, n_ui, n_tg, span;
  always #50 clk = ~clk;
  tpr_timer_pair dut (.clk(clk), .rst(rst), .pair_mode_field(mode),
    .pwm_cycle_select(pwm), .upper_clock_select(ucs), .lower_tick(lt), .upper_tick(3'h0),
    .lower_run_bit(lr), .upper_run_bit(ur), .dbuf_enable(db), .lower_cmp_wr(lw),
    .upper_cmp_wr(uw), .cmp_wdata(wd), .flop_cmd(fcmd), .toggle_enable(te),
    .toggle_source_upper(1'b0), .lower_counter(lc), .upper_counter(uc),
    .lower_compare_reg(lcr), .upper_compare_reg(ucr), .lower_match(lm), .upper_match(um),
    .lower_match_irq(li), .upper_match_irq(ui), .pulse_out_pin(pin));
  always @(posedge clk) begin
    n_lm <= n_lm + lm;
    n_li <= n_li + li;
    n_ui <= n_ui + ui;
    n_tg <= n_tg + (pin != pin_q);
    pin_q <= pin;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : cyc
  task automatic chk(input bit ok);
    comparisons++;
    if (!ok) begin
      mismatches++;
      $display("[ERR] %0t mismatch", $time);
    end
  endtask : chk
  task automatic zero();
    n_lm = 0; n_li = 0; n_ui = 0; n_tg = 0;
  endtask : zero
  task automatic halt();
    lt = 0; lr = 0; ur = 0;
    cyc(2);
    zero();
  endtask : halt
  task automatic wr(input bit up, input logic [7:0] v);
    lw = !up; uw = up; wd = v;
    cyc(1);
    lw = 0; uw = 0;
  endtask : wr
  task automatic meas(input bit sel);
    span = 0;
    lr = 1; ur = 1; lt = 1;
    do begin
      cyc(1);
      span++;
    end while ((sel ? li : ui) !== 1'b1 && span < 600);
  endtask : meas
  task automatic print_verdict();
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic t_cascade();
    halt();
    wr(0, 8'h02);
    wr(1, 8'h00);
    lr = 1; ur = 1; lt = 1;
    cyc(20);
    lt = 0;
    cyc(3);
    chk(n_lm == 10 && n_li == 10);
    chk(uc === 8'h0A);
  endtask : t_cascade
  task automatic t_wide();
    halt();
    mode = 2'h1;
    ucs = 2'h2;
    wr(0, 8'h04);
    wr(1, 8'h01);
    meas(0);
    chk(span == 260);
    chk(ucr === 8'h01 && lcr === 8'h04);
    chk(n_li == 0 && n_lm > 0);
    chk(lc === 8'h00 && uc === 8'h00);
    chk(um === 1'b1 && ui === 1'b1);
    halt();
    wr(0, 8'h04);
    lr = 1; ur = 1; lt = 1;
    cyc(300);
    chk(n_ui == 0);
    halt();
    wr(1, 8'h01);
    meas(0);
    chk(span == 260);
  endtask : t_wide
  task automatic t_pulse();
    halt();
    mode = 2'h2; te = 1; fcmd = 2'h1;
    wr(0, 8'h03);
    wr(1, 8'h08);
    fcmd = 0;
    chk(pin === 1'b1);
    lr = 1; ur = 1; lt = 1;
    zero();
    cyc(80);
    chk(n_tg >= 19 && n_tg <= 21 && uc === 8'h00);
    db = 1;
    wr(0, 8'h05);
    chk(lcr === 8'h03);
    cyc(10);
    chk(lcr === 8'h05);
    halt();
    fcmd = 2'h2;
    cyc(1);
    fcmd = 0;
    cyc(1);
    chk(pin === 1'b0);
  endtask : t_pulse
  task automatic t_pwm();
    for (int k = 1; k < 4; k++) begin
      halt();
      mode = 2'h3; pwm = k[1:0]; db = 0;
      wr(0, 8'h10);
      meas(1);
      zero();
      meas(1);
      chk(span == (1 << (5 + k)) && n_tg == 2);
      db = 1;
      wr(0, 8'h20);
      chk(lcr === 8'h10);
      meas(1);
      cyc(1);
      chk(lcr === 8'h20);
    end
  endtask : t_pwm
  initial begin
    cyc(16);
    rst = 0;
    cyc(1);
    chk(lc === 8'h00 && pin === 1'b0 && lcr === 8'h00);
    t_cascade();
    t_wide();
    t_pulse();
    t_pwm();
    print_verdict();
  end
  initial begin
    #2000000;
    mismatches++;
    print_verdict();
  end
endmodule : tpr_timer_pair_tb_top
